// ---- modem_lines_rx_dma_ready.v ----
// call-alert status, send-request control and receive dma ready, with an apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "modem_lines_map.vh"

// Behaviour
// - status bit 6 shows call-alert input now
// - bit 2 set on call-alert rising edge
// - enabled rising edge raises interrupt request
// - control bit 1 set drives send-request low unless loop mode is on
// - send-request high on reset, loop, bit clear
// - send-request never affects transmit or receive
// - fifo mode: control bit 3 picks dma type
// - character mode uses dma mode 0 only
// - mode 1: controller drains fifo without pause
// - mode 0: ready low while any character held
// - mode 0: ready high when nothing held
// - mode 1: ready low on trigger or timeout
// - mode 1: ready stays low until empty
// - master reset clears registers, sets outputs
module modem_lines_rx_dma_ready (
    input  wire        clk,              // 50 mhz system clock
    input  wire        rst,              // master reset, synchronous, active high
    input  wire        psel,             // apb select
    input  wire        penable,          // apb access phase
    input  wire        pwrite,           // apb direction
    input  wire [11:0] paddr,            // apb byte address
    input  wire [31:0] pwdata,           // apb write data
    output wire        pready,           // apb ready
    output reg  [31:0] prdata,           // apb read data
    output wire        pslverr,          // apb error
    input  wire        call_alert_in,    // call-alert level from the modem
    output reg         sendRequestN,     // send-request to the modem, active low
    input  wire [4:0]  rxCount,          // characters in receive fifo plus holding register
    input  wire        rxTriggerHit,     // receive trigger level reached
    input  wire        rxTimeout,        // receive time-out
    output reg         receive_dma_ready_n, // receive dma ready, active low
    output wire        modemStatusIrq,   // modem status interrupt request to uart core
    output wire        irq               // block interrupt, level, active high
);

    // ----------------------------------------------------------------
    // registers and internal signals
    // ----------------------------------------------------------------
    reg  [7:0] modem_control_reg;        // modem control
    reg  [7:0] fifoControl_reg;          // fifo control
    reg  [1:0] irqEnable_reg;            // interrupt enable
    reg        callAlertPrev_reg;        // last sampled call-alert level
    reg        dmaLatched_reg;           // mode 1 ready latch
    reg        call_alert_changed;       // change flag in modem status
    wire [1:0] irqStatus;                // sticky event bits
    wire       apbWrite;                 // write access completes
    wire       apbRead;                  // read access completes
    wire       mappedAddr;               // address hits a register
    wire       callAlertRise;            // low to high edge seen
    wire       fifo_enable_bit;          // fifos on
    wire       dma_mode_select_bit;      // dma type select
    wire       dmaMode1;                 // effective mode 1
    wire       anyHeld;                  // at least one character held
    wire       statusRead;               // modem status read
    wire       loopMode;                 // loop mode active
    reg        readyNext;                // next ready level
    reg        readyPrev_reg;            // ready on the prior cycle
    wire [1:0] evtSet;                   // event pulses
    wire [1:0] evtClr;                   // clear pulses

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // zero wait states keep the bus simple; every access ends in its first access cycle
    assign pready     = 1'b1;
    assign apbWrite   = psel & penable & pwrite;
    assign apbRead    = psel & penable & ~pwrite;
    assign mappedAddr = (paddr == `OFF_MODEM_STATUS)  || (paddr == `OFF_MODEM_CONTROL) ||
                        (paddr == `OFF_FIFO_CONTROL)  || (paddr == `OFF_IRQ_STATUS)    ||
                        (paddr == `OFF_IRQ_CLEAR)     || (paddr == `OFF_IRQ_ENABLE)    ||
                        (paddr == `OFF_RX_STATUS);
    // unmapped addresses answer with an error and read zero
    assign pslverr    = psel & penable & ~mappedAddr;
    assign statusRead = apbRead & (paddr == `OFF_MODEM_STATUS);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // writes take effect on the access edge only
    always @(posedge clk) begin
        if (rst) begin
            modem_control_reg <= `RST_MODEM_CONTROL;
            fifoControl_reg   <= `RST_FIFO_CONTROL;
            irqEnable_reg     <= `RST_IRQ_ENABLE;
        end else if (apbWrite) begin
            if (paddr == `OFF_MODEM_CONTROL) begin
                modem_control_reg <= pwdata[7:0];
            end else if (paddr == `OFF_FIFO_CONTROL) begin
                fifoControl_reg <= pwdata[7:0];
            end else if (paddr == `OFF_IRQ_ENABLE) begin
                irqEnable_reg <= pwdata[`EVT_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // call-alert edge and change flag
    // ----------------------------------------------------------------
    assign callAlertRise = call_alert_in & ~callAlertPrev_reg;

    // a rise in the read cycle wins so no edge is lost between reads
    always @(posedge clk) begin
        if (rst) begin
            callAlertPrev_reg  <= 1'b0;
            call_alert_changed <= 1'b0;
        end else begin
            callAlertPrev_reg <= call_alert_in;
            if (callAlertRise) begin
                call_alert_changed <= 1'b1;
            end else if (statusRead) begin
                call_alert_changed <= 1'b0;
            end
        end
    end

    // modem status interrupt toward the uart core, from the change flag
    assign modemStatusIrq = call_alert_changed & modem_control_reg[`BIT_MODEM_IRQ_EN];

    // ----------------------------------------------------------------
    // send-request output
    // ----------------------------------------------------------------
    assign loopMode = modem_control_reg[`BIT_LOOP_MODE];

    // the pin only reports intent; nothing in the datapath reads it
    always @(posedge clk) begin
        if (rst) begin
            sendRequestN <= 1'b1;
        end else begin
            sendRequestN <= ~(modem_control_reg[`BIT_SEND_REQUEST] & ~loopMode);
        end
    end

    // ----------------------------------------------------------------
    // receive dma ready
    // ----------------------------------------------------------------
    assign fifo_enable_bit     = fifoControl_reg[`BIT_FIFO_ENABLE];
    assign dma_mode_select_bit = fifoControl_reg[`BIT_DMA_MODE_SELECT];
    assign dmaMode1            = fifo_enable_bit & dma_mode_select_bit;
    assign anyHeld             = (rxCount != 5'h00);

    // mode 1 relies on the controller draining to empty in one burst
    always @* begin
        if (dmaMode1) begin
            readyNext = ~(anyHeld & (dmaLatched_reg | rxTriggerHit | rxTimeout));
        end else begin
            readyNext = ~anyHeld;
        end
    end

    // latch holds mode 1 ready active until the fifo is empty
    always @(posedge clk) begin
        if (rst) begin
            dmaLatched_reg      <= 1'b0;
            receive_dma_ready_n <= 1'b1;
            readyPrev_reg       <= 1'b1;
        end else begin
            dmaLatched_reg      <= dmaMode1 & ~readyNext;
            receive_dma_ready_n <= readyNext;
            readyPrev_reg       <= receive_dma_ready_n;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, clear and enable
    // ----------------------------------------------------------------
    assign evtSet[`BIT_EVT_CALL_ALERT] = callAlertRise;
    assign evtSet[`BIT_EVT_DMA_READY]  = readyPrev_reg & ~receive_dma_ready_n;
    assign evtClr = (apbWrite && paddr == `OFF_IRQ_CLEAR) ? pwdata[`EVT_WIDTH-1:0] : 2'h0;

    genvar gi;
    generate
        for (gi = 0; gi < `EVT_WIDTH; gi = gi + 1) begin : gEvt
            edge_flag uFlag (
                .clk        (clk),
                .rst        (rst),
                .setPulse   (evtSet[gi]),
                .clearPulse (evtClr[gi]),
                .flag       (irqStatus[gi])
            );
        end
    endgenerate

    // level interrupt while an enabled status bit stands
    assign irq = |(irqStatus & irqEnable_reg);

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always @* begin
        prdata = 32'h00000000;
        if (paddr == `OFF_MODEM_STATUS) begin
            prdata[`BIT_CALL_ALERT_NOW]     = call_alert_in;
            prdata[`BIT_CALL_ALERT_CHANGED] = call_alert_changed;
        end else if (paddr == `OFF_MODEM_CONTROL) begin
            prdata[7:0] = modem_control_reg;
        end else if (paddr == `OFF_FIFO_CONTROL) begin
            prdata[7:0] = fifoControl_reg;
        end else if (paddr == `OFF_IRQ_STATUS) begin
            prdata[1:0] = irqStatus;
        end else if (paddr == `OFF_IRQ_ENABLE) begin
            prdata[1:0] = irqEnable_reg;
        end else if (paddr == `OFF_RX_STATUS) begin
            prdata[4:0] = rxCount;
            prdata[8]   = receive_dma_ready_n;
            prdata[9]   = dmaMode1;
        end
    end

endmodule

`default_nettype wire

// ---- modem_lines_map.vh ----
// register offsets, field positions, reset values for the modem line and receive dma block
`ifndef MODEM_LINES_MAP_VH
`define MODEM_LINES_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_MODEM_STATUS   12'h000
`define OFF_MODEM_CONTROL  12'h004
`define OFF_FIFO_CONTROL   12'h008
`define OFF_IRQ_STATUS     12'h00c
`define OFF_IRQ_CLEAR      12'h010
`define OFF_IRQ_ENABLE     12'h014
`define OFF_RX_STATUS      12'h018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_CALL_ALERT_NOW     6
`define BIT_CALL_ALERT_CHANGED 2
`define BIT_SEND_REQUEST       1
`define BIT_LOOP_MODE          4
`define BIT_MODEM_IRQ_EN       0
`define BIT_FIFO_ENABLE        0
`define BIT_DMA_MODE_SELECT    3
`define BIT_EVT_CALL_ALERT     0
`define BIT_EVT_DMA_READY      1

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define RST_MODEM_CONTROL  8'h00
`define RST_FIFO_CONTROL   8'h00
`define RST_IRQ_ENABLE     2'h0
`define EVT_WIDTH          2

`endif

// ---- edge_flag.v ----
// sticky flag set by a hardware event, cleared by a software strobe
`timescale 1ns/1ps
`default_nettype none

module edge_flag (
    input  wire clk,       // system clock
    input  wire rst,       // synchronous reset, active high
    input  wire setPulse,  // hardware event
    input  wire clearPulse,// software clear
    output reg  flag       // sticky flag
);

    // ----------------------------------------------------------------
    // flag storage
    // ----------------------------------------------------------------
    // set beats clear so an event in the clearing cycle survives
    always @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (setPulse) begin
            flag <= 1'b1;
        end else if (clearPulse) begin
            flag <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- modem_lines_checker.sv ----
// port checker for the call-alert, send-request and receive dma ready block
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// checker module
// ------------------------------------------------------------
module modem_lines_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        call_alert_in,
    input wire logic        sendRequestN,
    input wire logic [4:0]  rxCount,
    input wire logic        rxTriggerHit,
    input wire logic        rxTimeout,
    input wire logic        receive_dma_ready_n,
    input wire logic        modemStatusIrq,
    input wire logic        irq
);
    logic [7:0] mcrReg;    // shadow of modem control
    logic [7:0] fcrReg;    // shadow of fifo control
    logic [2:0] alertReg;  // last call-alert samples, for a settled level
    logic       mode1Reg;  // mode one a cycle ago
    wire        mode1 = fcrReg[0] & fcrReg[3];
    wire        rtsWantN = ~(mcrReg[1] & ~mcrReg[4]);  // loop mode wins
    // shadows follow completed apb writes
    always_ff @(posedge clk) begin
        alertReg <= {alertReg[1:0], call_alert_in};
        mode1Reg <= mode1;
        if (rst) begin
            mcrReg <= 8'h00;
            fcrReg <= 8'h00;
        end else if (psel && penable && pwrite && pready) begin
            if (paddr == 12'h004) mcrReg <= pwdata[7:0];
            if (paddr == 12'h008) fcrReg <= pwdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    reset_levels_a: assert property (disable iff (1'b0) rst |=> sendRequestN && receive_dma_ready_n && !irq)
        else $error("outputs off reset level");
    send_request_a: assert property ($stable(rtsWantN) |-> sendRequestN == rtsWantN)
        else $error("send-request level wrong");
    alert_level_a: assert property (psel && penable && !pwrite && paddr == 12'h000
        && alertReg == {3{call_alert_in}} |-> prdata[6] == call_alert_in) else $error("call-alert level wrong");
    alert_irq_a: assert property ($rose(call_alert_in) && mcrReg[0] |-> ##[1:3] modemStatusIrq)
        else $error("no modem status request");
    mode0_ready_a: assert property (!mode1 && !mode1Reg |-> receive_dma_ready_n == ($past(rxCount) == 5'd0))
        else $error("mode0 ready wrong");
    mode1_start_a: assert property (mode1 && receive_dma_ready_n && rxCount != 5'd0
        && (rxTriggerHit || rxTimeout) |=> !receive_dma_ready_n) else $error("mode1 ready late");
    mode1_quiet_a: assert property (mode1 && receive_dma_ready_n && !rxTriggerHit && !rxTimeout
        |=> receive_dma_ready_n) else $error("mode1 ready early");
    mode1_hold_a: assert property (mode1 && !receive_dma_ready_n && rxCount != 5'd0 |=> !receive_dma_ready_n)
        else $error("mode1 ready dropped");
    mode1_empty_a: assert property (mode1 && rxCount == 5'd0 |=> receive_dma_ready_n)
        else $error("ready held when empty");
endmodule
`default_nettype wire

// ---- rx_side_model.sv ----
// receive fifo fill and dma controller standing beside the block
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// fifo and dma model
// ------------------------------------------------------------
module rx_side_model #(
    parameter int TRIG = 4  // receive trigger level in characters
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       addEn,
    input  wire logic [4:0] addN,
    input  wire logic       dmaEn,
    input  wire logic       readyN,
    output var  logic [4:0] rxCount,
    output var  logic       rxTriggerHit
);
    // one character per cycle while ready is low, no pause until empty
    always_ff @(posedge clk) begin
        if (rst) begin
            rxCount <= 5'd0;
        end else if (addEn) begin
            rxCount <= rxCount + addN;
        end else if (dmaEn && !readyN && rxCount != 5'd0) begin
            rxCount <= rxCount - 5'd1;
        end
    end
    assign rxTriggerHit = rxCount >= 5'(TRIG);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the modem line and receive dma block
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic        call_alert_in = 1'b0, rxTimeout = 1'b0, addEn = 1'b0, dmaEn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [4:0]  addN = 5'd0;
    wire         pready, pslverr, sendRequestN, receive_dma_ready_n, modemStatusIrq, irq, rxTriggerHit;
    wire  [31:0] prdata;
    wire  [4:0]  rxCount;
    int          nErrors = 0, checksDone = 0;
    logic [7:0]  fcrTab [4] = '{8'h00, 8'h08, 8'h01, 8'h09};  // every dma mode pairing
    always #10 clk = ~clk;
    modem_lines_rx_dma_ready u_modem_lines_rx_dma_ready (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .call_alert_in, .sendRequestN, .rxCount, .rxTriggerHit, .rxTimeout,
        .receive_dma_ready_n, .modemStatusIrq, .irq);
    rx_side_model u_rx_side_model (.clk, .rst, .addEn, .addN, .dmaEn, .readyN(receive_dma_ready_n), .rxCount,
        .rxTriggerHit);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    // outputs looked at on the falling edge, well clear of updates
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic addChars(input logic [4:0] n);
        @(posedge clk);
        addN <= n;
        addEn <= 1'b1;
        @(posedge clk);
        addEn <= 1'b0;
    endtask
    task automatic summarize();
        if (nErrors == 0 && checksDone > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        nErrors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(12'h004, 32'h0);
        chk(sendRequestN, 1'b1);
        apb(1'b1, 12'h004, 32'h2);
        settle(2);
        chk(sendRequestN, 1'b0);
        apb(1'b1, 12'h004, 32'h12);
        settle(2);
        chk(sendRequestN, 1'b1);
        apb(1'b1, 12'h014, 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        call_alert_in <= 1'b1;
        settle(3);
        chk(irq, 1'b1);
        rd(12'h000, 32'h44);
        rd(12'h000, 32'h40);
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b1, 12'h014, 32'h0);
        call_alert_in <= 1'b0;
        settle(3);
        chk(irq, 1'b0);
        rd(12'h000, 32'h0);
        call_alert_in <= 1'b1;
        settle(3);
        chk(irq, 1'b0);
        rd(12'h00c, 32'h1);
        apb(1'b1, 12'h010, 32'h1);
        rd(12'h01c, 32'h0);
        chk(err, 1'b1);
        foreach (fcrTab[i]) begin
            apb(1'b1, 12'h008, {24'h0, fcrTab[i]});
            addChars(5'd2);
            settle(3);
            chk(receive_dma_ready_n, fcrTab[i] == 8'h09);
            if (fcrTab[i] == 8'h09) begin
                addChars(5'd2);
                settle(3);
                rd(12'h018, 32'h204);
            end
            @(posedge clk);
            dmaEn <= 1'b1;
            settle(8);
            chk(receive_dma_ready_n, 1'b1);
            dmaEn <= 1'b0;
        end
        addChars(5'd1);
        rxTimeout <= 1'b1;
        @(posedge clk);
        rxTimeout <= 1'b0;
        settle(2);
        chk(receive_dma_ready_n, 1'b0);
        summarize();
    end
endmodule
bind modem_lines_rx_dma_ready modem_lines_checker u_modem_lines_checker (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .call_alert_in, .sendRequestN, .rxCount, .rxTriggerHit,
    .rxTimeout, .receive_dma_ready_n, .modemStatusIrq, .irq);
`default_nettype wire
